// >>> inc/cpu_words_defines.vh
// constants for the processor mode word and process status word
`ifndef CPU_WORDS_DEFINES_VH
`define CPU_WORDS_DEFINES_VH

// bit numbering: documented bit n (1 = msb) sits at index 16-n
`define MW_INT_EN       15
`define MW_VECTORED     14
`define MW_ZERO_HI      13
`define MW_ZERO_LO      8
`define MW_RSET_HI      7
`define MW_RSET_LO      5
`define MW_MAPPED_IO    4
`define MW_PX_EN        3
`define MW_SEGMENT      2
`define MW_MCHK_HI      1
`define MW_MCHK_LO      0

`define SW_CARRY        15
`define SW_PRECISION    14
`define SW_LINK         13
`define SW_MODE_HI      12
`define SW_MODE_LO      10
`define SW_FLT_EXC      9
`define SW_INT_EXC      8
`define SW_LESS         7
`define SW_EQUAL        6
`define SW_DEC_EXC      5
`define SW_CHAR_FMT     4
`define SW_ROUND        3
`define SW_SPARE        2
`define SW_NOT_DISP     1
`define SW_SAVE_DONE    0
`define SW_SHIFT_HI     7
`define SW_SHIFT_LO     0

// reset values are not documented; chosen as all zero
`define MODE_WORD_RST   16'h0000
`define STATUS_WORD_RST 16'h0000
// mask of mode word bits kept; the cleared bits 13:8 always read zero
`define MW_ZERO_MASK    16'hc0ff

// addressing mode codes
`define AM_16S          3'h0
`define AM_32S          3'h1
`define AM_64R          3'h2
`define AM_32R          3'h3
`define AM_32I          3'h4
`define AM_64V          3'h6

// machine check reporting codes
`define MC_NONE         2'h0
`define MC_PARITY       2'h1
`define MC_UNRECOV      2'h2
`define MC_ALL          2'h3

// instruction opcodes on the control command port
`define OP_NONE         5'h00
`define OP_INT_ON       5'h01
`define OP_INT_OFF      5'h02
`define OP_VECTORED     5'h03
`define OP_STANDARD     5'h04
`define OP_MCHK_ENTER   5'h05
`define OP_MCHK_LEAVE   5'h06
`define OP_MCHK_RESET   5'h07
`define OP_LOAD_PSW     5'h08
`define OP_DOUBLE       5'h09
`define OP_SINGLE       5'h0a
`define OP_ENTER_16S    5'h0b
`define OP_ENTER_32S    5'h0c
`define OP_ENTER_64R    5'h0d
`define OP_ENTER_32R    5'h0e
`define OP_ENTER_32I    5'h0f
`define OP_ENTER_64V    5'h10
`define OP_FLAG_RESET   5'h11
`define OP_FLAG_SET     5'h12
`define OP_SHIFT_READ   5'h13
`define OP_ACC_TO_SW    5'h14
`define OP_SW_TO_ACC    5'h15
`define OP_SW_READ      5'h16
`define OP_SW_WRITE     5'h17

// machine check entry and leave values (not documented)
`define MC_ENTER_VAL    2'h3
`define MC_LEAVE_VAL    2'h0

`endif

// >>> hw/instr_decode.v
// privilege check and opcode decode for the control word instructions
`default_nettype none
`include "cpu_words_defines.vh"

module instr_decode (
    input  wire [4:0] op_i,
    input  wire       valid_i,
    input  wire [2:0] ring_i,
    output reg        priv_o,
    output reg        allowed_o,
    output reg        refused_o
);
    // only ring zero may run the privileged ones
    always @* begin
        case (op_i)
            `OP_INT_ON, `OP_INT_OFF, `OP_VECTORED, `OP_STANDARD,
            `OP_MCHK_ENTER, `OP_MCHK_LEAVE, `OP_MCHK_RESET,
            `OP_LOAD_PSW: priv_o = 1'b1;
            default:      priv_o = 1'b0;
        endcase
        allowed_o = valid_i && (op_i != `OP_NONE)
                    && (!priv_o || ring_i == 3'h0); // [R1]
        refused_o = valid_i && priv_o && (ring_i != 3'h0);
    end
endmodule
`default_nettype wire

// >>> hw/cpu_mode_and_status_words.v
// processor mode word and process status word with their instructions
`default_nettype none
`include "cpu_words_defines.vh"

// Overview of operation
// R1: privileged control word instructions run only in ring zero
// R2: interrupt-on sets mode bit 1, interrupt-off clears it
// R3: vectored-mode sets mode bit 2, standard-mode clears it
// R4: mode bits 9-11 name register set; only process exchange changes it
// R5: mode bit 12 selects mapped (1) or unmapped (0) I/O
// R6: mode bit 13 enables process exchange when one
// R7: mode bit 14 turns segmented translation on when one
// R8: mode bits 15-16 pick machine check reporting level
// R9: machine-check-reset clears bits 15-16, holds interrupts one instruction
// R10: software avoids generic store and psw loads of protected fields
// R11: older modes: status holds flag, precision, mode, enables, shift count
// R12: older modes: double sets status bit 2, single clears it
// R13: status bits 4-6 encode addressing mode; 101, 111 unused
// R14: each enter-mode instruction writes its code into bits 4-6
// R15: status bit 7 zero makes float errors fault, one only flags
// R16: newer modes: bits 8, 11 one make errors also fault
// R17: newer modes: bit 2 kept zero, bit 3 link, 9 less, 10 equal
// R18: status bit 12 selects 8-bit (0) or 7-bit (1) characters
// R19: status bit 13 selects float rounding when one
// R20: bit 15 zero in dispatcher, 16 save done; only exchange changes them
// R21: flag-reset clears carry-style flag, flag-set sets it
// R22: transfers copy whole status word; shift read copies bits 9-16; status word writes here keep bits 15-16
// R23: arithmetic sets carry-style flag on overflow, link on carry
// R24: mode bits 3-8 always held and read as zero

module cpu_mode_and_status_words (
    input  wire        sys_clk_i,
    input  wire        rst_n_i,
    // instruction command from the execution unit
    input  wire        instr_valid_i,
    input  wire [4:0]  instr_op_i,
    input  wire [2:0]  ring_i,
    input  wire [15:0] operand_i,
    input  wire [15:0] psw_mode_i,
    // arithmetic results from the execution unit
    input  wire        arith_update_i,
    input  wire        overflow_i,
    input  wire        carry_out_i,
    input  wire        cc_update_i,
    input  wire        less_than_i,
    input  wire        equal_zero_i,
    input  wire        float_err_i,
    input  wire        int_err_i,
    input  wire        dec_err_i,
    // process exchange port
    input  wire        px_rset_we_i,
    input  wire [2:0]  px_rset_i,
    input  wire        px_disp_we_i,
    input  wire        px_not_disp_i,
    input  wire        px_save_done_i,
    // word outputs
    output reg  [15:0] mode_word_o,
    output reg  [15:0] status_word_o,
    output reg  [15:0] read_data_o,
    output reg         read_valid_o,
    output wire        refused_o,
    output reg         fault_o,
    // decoded controls
    output wire        interrupt_en_o,
    output wire        vectored_o,
    output wire [2:0]  active_register_set_o,
    output wire        mapped_io_bit_o,
    output wire        process_exchange_o,
    output wire        segmented_o,
    output wire [1:0]  machine_check_reporting_o,
    output wire [2:0]  addr_mode_o,
    output wire        newer_mode_o,
    output wire        float_rounding_bit_o,
    output wire        char_7bit_o,
    output reg         int_hold_o
);
    reg  [15:0] mode_reg;
    reg  [15:0] mode_next;
    reg  [15:0] stat_reg;
    reg  [15:0] stat_next;
    reg         hold_reg;
    reg         hold_next;
    reg  [15:0] rd_next;
    reg         rdv_next;
    reg         fault_next;
    wire        allowed;
    wire        newer;

    // true for the two newer addressing modes
    function is_newer;
        input [2:0] m;
        begin
            is_newer = (m == `AM_64V) || (m == `AM_32I);
        end
    endfunction

    // status word write filter; keeps exchange-owned bits and bit 2 rule
    function [15:0] filter_status;
        input [15:0] val;
        input [15:0] old;
        begin
            filter_status = val;
            filter_status[`SW_NOT_DISP] = old[`SW_NOT_DISP];   // [R20]
            filter_status[`SW_SAVE_DONE] = old[`SW_SAVE_DONE]; // [R20]
            if (is_newer(val[`SW_MODE_HI:`SW_MODE_LO]))
                filter_status[`SW_PRECISION] = 1'b0;          // [R17]
        end
    endfunction

    instr_decode u_dec (
        .op_i      (instr_op_i),
        .valid_i   (instr_valid_i),
        .ring_i    (ring_i),
        .priv_o    (),
        .allowed_o (allowed),
        .refused_o (refused_o)
    );

    assign newer = is_newer(stat_reg[`SW_MODE_HI:`SW_MODE_LO]);

    // next-state of both words; instruction first, then results, exchange
    always @* begin
        mode_next  = mode_reg;
        stat_next  = stat_reg;
        hold_next  = 1'b0;
        rd_next    = read_data_o;
        rdv_next   = 1'b0;
        fault_next = 1'b0;
        if (allowed) begin
            case (instr_op_i)
                `OP_INT_ON:   mode_next[`MW_INT_EN] = 1'b1;   // [R2]
                `OP_INT_OFF:  mode_next[`MW_INT_EN] = 1'b0;   // [R2]
                `OP_VECTORED: mode_next[`MW_VECTORED] = 1'b1; // [R3]
                `OP_STANDARD: mode_next[`MW_VECTORED] = 1'b0; // [R3]
                `OP_MCHK_ENTER:
                    mode_next[`MW_MCHK_HI:`MW_MCHK_LO] = `MC_ENTER_VAL;
                `OP_MCHK_LEAVE:
                    mode_next[`MW_MCHK_HI:`MW_MCHK_LO] = `MC_LEAVE_VAL;
                `OP_MCHK_RESET: begin
                    mode_next[`MW_MCHK_HI:`MW_MCHK_LO] = `MC_NONE; // [R9]
                    hold_next = 1'b1;                              // [R9]
                end
                `OP_LOAD_PSW: begin
                    // register set field kept; software avoids it anyway
                    mode_next = psw_mode_i;
                    mode_next[`MW_RSET_HI:`MW_RSET_LO] =
                        mode_reg[`MW_RSET_HI:`MW_RSET_LO];       // [R4] [R10]
                    stat_next = filter_status(operand_i, stat_reg);
                end
                `OP_DOUBLE: begin
                    if (!newer) stat_next[`SW_PRECISION] = 1'b1; // [R12]
                end
                `OP_SINGLE: begin
                    if (!newer) stat_next[`SW_PRECISION] = 1'b0; // [R12]
                end
                `OP_ENTER_16S:
                    stat_next[`SW_MODE_HI:`SW_MODE_LO] = `AM_16S; // [R14]
                `OP_ENTER_32S:
                    stat_next[`SW_MODE_HI:`SW_MODE_LO] = `AM_32S; // [R14]
                `OP_ENTER_64R:
                    stat_next[`SW_MODE_HI:`SW_MODE_LO] = `AM_64R; // [R14]
                `OP_ENTER_32R:
                    stat_next[`SW_MODE_HI:`SW_MODE_LO] = `AM_32R; // [R14]
                `OP_ENTER_32I:
                    stat_next[`SW_MODE_HI:`SW_MODE_LO] = `AM_32I; // [R14]
                `OP_ENTER_64V:
                    stat_next[`SW_MODE_HI:`SW_MODE_LO] = `AM_64V; // [R14]
                `OP_FLAG_RESET: stat_next[`SW_CARRY] = 1'b0;      // [R21]
                `OP_FLAG_SET:   stat_next[`SW_CARRY] = 1'b1;      // [R21]
                `OP_SHIFT_READ: begin
                    // shift count into low byte, high byte of acc kept
                    rd_next  = {operand_i[15:8],
                                stat_reg[`SW_SHIFT_HI:`SW_SHIFT_LO]}; // [R22]
                    rdv_next = 1'b1;
                end
                `OP_ACC_TO_SW, `OP_SW_WRITE:
                    stat_next = filter_status(operand_i, stat_reg); // [R22]
                `OP_SW_TO_ACC, `OP_SW_READ: begin
                    rd_next  = stat_reg;                            // [R22]
                    rdv_next = 1'b1;
                end
                default: ;
            endcase
        end
        // execution results land after the instruction's own effect
        if (arith_update_i) begin
            if (overflow_i) stat_next[`SW_CARRY] = 1'b1;          // [R23]
            if (carry_out_i && newer) stat_next[`SW_LINK] = 1'b1; // [R23]
        end
        if (cc_update_i && newer) begin
            stat_next[`SW_LESS]  = less_than_i;                   // [R17]
            stat_next[`SW_EQUAL] = equal_zero_i;                  // [R17]
        end
        // error handling: flag on float, integer and newer-mode decimal errors, fault per enable bit
        if (float_err_i) begin
            stat_next[`SW_CARRY] = 1'b1;                          // [R15]
            if (!stat_reg[`SW_FLT_EXC]) fault_next = 1'b1;        // [R15]
        end
        if (int_err_i) begin
            stat_next[`SW_CARRY] = 1'b1;                          // [R16]
            // older modes fault on a clear enable, newer on a set one
            if (stat_reg[`SW_INT_EXC] == newer) fault_next = 1'b1; // [R11]
        end
        if (dec_err_i && newer) begin
            stat_next[`SW_CARRY] = 1'b1;                          // [R16]
            if (stat_reg[`SW_DEC_EXC]) fault_next = 1'b1;         // [R16]
        end
        // process exchange owns register set and dispatcher bits
        if (px_rset_we_i)
            mode_next[`MW_RSET_HI:`MW_RSET_LO] = px_rset_i;      // [R4]
        if (px_disp_we_i) begin
            stat_next[`SW_NOT_DISP]  = px_not_disp_i;            // [R20]
            stat_next[`SW_SAVE_DONE] = px_save_done_i;           // [R20]
        end
        if (is_newer(stat_next[`SW_MODE_HI:`SW_MODE_LO]))
            stat_next[`SW_PRECISION] = 1'b0;                     // [R17]
        mode_next = mode_next & `MW_ZERO_MASK;                   // [R24]
    end

    // state registers, synchronous reset
    always @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            mode_reg     <= `MODE_WORD_RST;
            stat_reg     <= `STATUS_WORD_RST;
            hold_reg     <= 1'b0;
            read_data_o  <= 16'h0000;
            read_valid_o <= 1'b0;
            fault_o      <= 1'b0;
        end else begin
            mode_reg     <= mode_next;
            stat_reg     <= stat_next;
            hold_reg     <= hold_next;
            read_data_o  <= rd_next;
            read_valid_o <= rdv_next;
            fault_o      <= fault_next;
        end
    end

    // hold lasts until the next instruction completes
    always @(posedge sys_clk_i) begin
        if (!rst_n_i)
            int_hold_o <= 1'b0;
        else if (hold_next)
            int_hold_o <= 1'b1;                                  // [R9]
        else if (instr_valid_i && instr_op_i != `OP_NONE)
            int_hold_o <= 1'b0;
    end

    // word outputs follow the registers
    always @* begin
        mode_word_o   = mode_reg;
        status_word_o = stat_reg;
    end

    // decoded fields
    assign interrupt_en_o = mode_reg[`MW_INT_EN] & ~int_hold_o;      // [R9]
    assign vectored_o     = mode_reg[`MW_VECTORED];                  // [R3]
    assign active_register_set_o = mode_reg[`MW_RSET_HI:`MW_RSET_LO];
    assign mapped_io_bit_o    = mode_reg[`MW_MAPPED_IO];             // [R5]
    assign process_exchange_o = mode_reg[`MW_PX_EN];                 // [R6]
    assign segmented_o        = mode_reg[`MW_SEGMENT];               // [R7]
    assign machine_check_reporting_o =
        mode_reg[`MW_MCHK_HI:`MW_MCHK_LO];                          // [R8]
    assign addr_mode_o  = stat_reg[`SW_MODE_HI:`SW_MODE_LO];        // [R13]
    assign newer_mode_o = newer;                                    // [R11]
    assign float_rounding_bit_o = stat_reg[`SW_ROUND];              // [R19]
    assign char_7bit_o  = stat_reg[`SW_CHAR_FMT];                   // [R18]
endmodule
`default_nettype wire

// >>> dv/words_monitor.sv
// assertion checker on the ports of the mode and status word block
`default_nettype none
`include "cpu_words_defines.vh"
module words_monitor (
    input wire logic        sys_clk_i,
    input wire logic        rst_n_i,
    input wire logic        instr_valid_i,
    input wire logic [4:0]  instr_op_i,
    input wire logic [2:0]  ring_i,
    input wire logic        px_rset_we_i,
    input wire logic        px_disp_we_i,
    input wire logic [15:0] mode_word_o,
    input wire logic [15:0] status_word_o,
    input wire logic        refused_o,
    input wire logic        fault_o,
    input wire logic        interrupt_en_o,
    input wire logic [2:0]  addr_mode_o,
    input wire logic        int_hold_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic pv;
    logic tk;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    // privileged opcodes form one contiguous range
    assign pv = instr_op_i >= `OP_INT_ON && instr_op_i <= `OP_LOAD_PSW;
    assign tk = instr_valid_i && (!pv || ring_i == 3'h0);
    chk_ring_refuse: assert property (instr_valid_i && pv && ring_i != 0
        |-> refused_o ##1 ((mode_word_o ^ $past(mode_word_o)) & 16'hff03) == 0)
        else $error("privileged op outside ring zero not refused");
    chk_ring_zero: assert property (tk |-> !refused_o)
        else $error("allowed op refused");
    chk_int_on: assert property (tk && instr_op_i == `OP_INT_ON
        |=> mode_word_o[15]) else $error("interrupt enable not set");
    chk_int_off: assert property (tk && instr_op_i == `OP_INT_OFF
        |=> !mode_word_o[15]) else $error("interrupt enable not cleared");
    chk_vect_mode: assert property (tk && instr_op_i == `OP_VECTORED
        |=> mode_word_o[14]) else $error("vectored mode not set");
    chk_rset_hold: assert property (!px_rset_we_i
        |=> $stable(mode_word_o[7:5])) else $error("register set changed");
    chk_zero_bits: assert property (mode_word_o[13:8] == 6'h00)
        else $error("mode word zero field not zero");
    chk_mchk_reset: assert property (tk && instr_op_i == `OP_MCHK_RESET
        |=> mode_word_o[1:0] == 2'h0 && int_hold_o && !interrupt_en_o)
        else $error("machine check reset wrong");
    chk_enter_64v: assert property (tk && instr_op_i == `OP_ENTER_64V
        |=> addr_mode_o == `AM_64V) else $error("addressing mode not 64v");
    chk_flag_set: assert property (tk && instr_op_i == `OP_FLAG_SET
        |=> status_word_o[15]) else $error("carry style flag not set");
    chk_disp_hold: assert property (!px_disp_we_i
        |=> $stable(status_word_o[1:0])) else $error("dispatcher bits moved");
    cov_refused: cover property (refused_o);
    cov_fault: cover property (fault_o);
    cov_hold: cover property (int_hold_o ##1 !int_hold_o);
endmodule
`default_nettype wire

// >>> dv/px_partner.sv
// far side model: process exchange writes of register set and dispatcher
`default_nettype none
module px_partner (
    input  wire logic       sys_clk_i,
    input  wire logic       req_i,
    input  wire logic       slow_i,
    input  wire logic [2:0] rset_i,
    input  wire logic [1:0] disp_i,
    output var  logic       rset_we_o,
    output var  logic [2:0] rset_o,
    output var  logic       disp_we_o,
    output var  logic       not_disp_o,
    output var  logic       save_done_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle lines show the inverse so stale values cannot pass for fresh
    initial begin
        {rset_we_o, rset_o, disp_we_o, not_disp_o, save_done_o} = 7'h00;
        forever begin
            @(posedge sys_clk_i);
            if (req_i) begin
                repeat (slow_i ? 4 : 0) @(posedge sys_clk_i);
                #1;
                {rset_we_o, disp_we_o} = 2'h3;
                rset_o = rset_i;
                {not_disp_o, save_done_o} = disp_i;
                @(posedge sys_clk_i);
                #1;
                {rset_we_o, disp_we_o} = 2'h0;
                rset_o = ~rset_i;
                {not_disp_o, save_done_o} = ~disp_i;
            end
        end
    end
endmodule
`default_nettype wire

// >>> dv/test_cpu_mode_and_status_words.sv
// self-checking bench for the mode and status word block
`default_nettype none
`include "cpu_words_defines.vh"
module test_cpu_mode_and_status_words;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk_i, rst_n_i, valid, px_req, px_slow, eh, erv, ef;
    logic        arith, ovf, cout, ccu, lt, eq, ferr, ierr, derr;
    logic [4:0]  op, ro;
    logic [2:0]  ring, px_val;
    logic [1:0]  px_disp;
    logic [15:0] opnd, psw, em, es, erd, rdat;
    logic [31:0] rs;
    wire logic        px_we, px_dwe, px_nd, px_sd, rv, refd, flt;
    wire logic [2:0]  px_rset;
    wire logic [15:0] mw, sw, rd;
    wire logic [16:0] dco;
    int          mismatches, total_checks, cyc;
    cpu_mode_and_status_words dut (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .instr_valid_i(valid),
        .instr_op_i(op), .ring_i(ring), .operand_i(opnd), .psw_mode_i(psw),
        .arith_update_i(arith), .overflow_i(ovf), .carry_out_i(cout),
        .cc_update_i(ccu), .less_than_i(lt), .equal_zero_i(eq),
        .float_err_i(ferr), .int_err_i(ierr), .dec_err_i(derr),
        .px_rset_we_i(px_we), .px_rset_i(px_rset), .px_disp_we_i(px_dwe),
        .px_not_disp_i(px_nd), .px_save_done_i(px_sd),
        .mode_word_o(mw), .status_word_o(sw), .read_data_o(rd),
        .read_valid_o(rv), .refused_o(refd), .fault_o(flt),
        .interrupt_en_o(dco[16]), .vectored_o(dco[15]),
        .active_register_set_o(dco[14:12]), .mapped_io_bit_o(dco[11]),
        .process_exchange_o(dco[10]), .segmented_o(dco[9]),
        .machine_check_reporting_o(dco[8:7]), .addr_mode_o(dco[6:4]),
        .newer_mode_o(dco[3]), .float_rounding_bit_o(dco[2]),
        .char_7bit_o(dco[1]), .int_hold_o(dco[0]));
    px_partner px (.sys_clk_i(sys_clk_i), .req_i(px_req), .slow_i(px_slow),
        .rset_i(px_val), .disp_i(px_disp), .rset_we_o(px_we),
        .rset_o(px_rset), .disp_we_o(px_dwe), .not_disp_o(px_nd),
        .save_done_o(px_sd));
    initial begin
        sys_clk_i = 1'b0;
        forever #4 sys_clk_i = ~sys_clk_i;
    end
    // cuts a hang short well past the expected run length
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        if (mismatches == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    function automatic logic nw();
        return es[12:10] == `AM_32I || es[12:10] == `AM_64V;
    endfunction
    // valid stays high between calls so instructions run back to back
    task automatic issue(input logic [4:0] o, input logic [2:0] r,
                         input logic [15:0] d, input logic [15:0] p);
        logic tk;
        tk = o > `OP_LOAD_PSW || r == 3'h0;
        {op, ring, opnd, psw, valid} = {o, r, d, p, 1'b1};
        #1;
        chk(refd, !tk);
        @(posedge sys_clk_i);
        #1;
        eh = 1'b0;
        if (tk) begin
            case (o)
                `OP_INT_ON: em[15] = 1'b1;
                `OP_INT_OFF: em[15] = 1'b0;
                `OP_VECTORED: em[14] = 1'b1;
                `OP_STANDARD: em[14] = 1'b0;
                `OP_MCHK_ENTER: em[1:0] = `MC_ENTER_VAL;
                `OP_MCHK_LEAVE: em[1:0] = `MC_LEAVE_VAL;
                `OP_MCHK_RESET: {em[1:0], eh} = 3'h1;
                `OP_LOAD_PSW: begin
                    em = p & 16'hc01f | em & 16'h00e0;
                    es = {d[15:2], es[1:0]};
                end
                `OP_DOUBLE: es[14] = 1'b1;
                `OP_SINGLE: es[14] = 1'b0;
                `OP_FLAG_RESET: es[15] = 1'b0;
                `OP_FLAG_SET: es[15] = 1'b1;
                `OP_ACC_TO_SW, `OP_SW_WRITE: es = {d[15:2], es[1:0]};
                `OP_SHIFT_READ: erd = {d[15:8], es[7:0]};
                `OP_SW_TO_ACC, `OP_SW_READ: erd = es;
                `OP_ENTER_64V: es[12:10] = `AM_64V;
                default: es[12:10] = 3'(o - `OP_ENTER_16S);
            endcase
        end
        if (nw()) es[14] = 1'b0;
        erv = tk && (o == `OP_SHIFT_READ || o == `OP_SW_TO_ACC);
        erv = erv || tk && o == `OP_SW_READ;
        chk(mw, em);
        chk(sw, es);
        chk(rv, erv);
        if (erv) chk(rd, erd);
        chk(dco, {em[15] & ~eh, em[14], em[7:0], es[12:10], nw(), es[3],
                  es[4], eh});
    endtask
    // one idle cycle so no input is driven twice in one step
    task automatic quiet();
        {valid, arith, ovf, cout, ccu, lt, eq, ferr, ierr, derr} = 10'h000;
        @(posedge sys_clk_i);
        #1;
    endtask
    task automatic ev(input logic [8:0] v);
        {arith, ovf, cout, ccu, lt, eq, ferr, ierr, derr} = v;
        @(posedge sys_clk_i);
        #1;
        ef = v[2] && !es[9] || v[1] && es[8] == nw() || v[0] && es[5] && nw();
        es[15] = es[15] | v[8] & v[7] | (|v[2:1]) | v[0] & nw();
        es[13] = es[13] | v[8] & v[6] & nw();
        if (v[5] && nw()) es[7:6] = v[4:3];
        chk(flt, ef);
        chk(sw, es);
    endtask
    task automatic pxw(input logic s, input logic [2:0] v,
                       input logic [1:0] dsp);
        {px_slow, px_val, px_disp, px_req} = {s, v, dsp, 1'b1};
        @(posedge sys_clk_i);
        #1;
        px_req = 1'b0;
        repeat (7) @(posedge sys_clk_i);
        #1;
        em[7:5] = v;
        es[1:0] = dsp;
        chk(mw, em);
        chk(sw, es);
    endtask
    initial begin
        {rst_n_i, px_req, px_slow, op, ring, opnd, psw} = 0;
        {px_val, px_disp, em, es, erd, eh, erv} = 0;
        rs = 32'hb5b80554;
        quiet();
        repeat (19) @(posedge sys_clk_i);
        #1;
        rst_n_i = 1'b1;
        // each privileged op refused outside ring zero, then taken
        for (int i = 1; i <= 8; i++) begin
            issue(5'(i), 3'h4, 16'h0000, 16'hffff);
            issue(5'(i), 3'h0, 16'h0000, 16'h8003);
        end
        issue(`OP_SINGLE, 3'h3, 16'h0000, 16'h0000);
        issue(`OP_DOUBLE, 3'h3, 16'h0000, 16'h0000);
        for (int i = `OP_ENTER_16S; i <= `OP_ENTER_64V; i++)
            issue(5'(i), 3'h1, 16'h0000, 16'h0000);
        // register set and dispatcher bits left alone by this load
        issue(`OP_LOAD_PSW, 3'h0, 16'h1938, 16'h9c1f);
        issue(`OP_FLAG_RESET, 3'h2, 16'h0000, 16'h0000);
        quiet();
        ev(9'h1c0);
        ev(9'h030);
        ev(9'h028);
        for (int j = 0; j < 2; j++) begin
            if (j == 1) begin
                quiet();
                issue(`OP_ACC_TO_SW, 3'h0, 16'h1a00, 16'h0000);
                quiet();
            end
            for (int k = 0; k < 3; k++) ev(9'(1 << k));
        end
        quiet();
        pxw(1'b0, 3'h5, 2'h3);
        pxw(1'b1, 3'h2, 2'h1);
        repeat (300) begin
            rs = xs(rs);
            ro = 5'(rs[7:0] % 8'd23 + 8'd1);
            rdat = rs[31:16] & 16'hbfff;
            rdat[12] = rdat[12] & ~rdat[10];
            issue(ro, rs[8] ? 3'h0 : rs[11:9], rdat, rs[15:0]);
            if (rs[13:12] == 2'h0) begin
                quiet();
                pxw(rs[14], rs[11:9], rs[17:16]);
            end
        end
        quiet();
        rst_n_i = 1'b0;
        repeat (3) @(posedge sys_clk_i);
        #1;
        rst_n_i = 1'b1;
        {em, es, eh} = 0;
        chk(mw, em);
        chk(sw, es);
        issue(`OP_VECTORED, 3'h0, 16'h0000, 16'h0000);
        issue(`OP_STANDARD, 3'h0, 16'h0000, 16'h0000);
        // older mode: no link or condition codes, clear enable faults
        quiet();
        ev(9'h1f8);
        ev(9'h002);
        end_of_test();
    end
endmodule
bind cpu_mode_and_status_words words_monitor mon (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .instr_valid_i(instr_valid_i),
    .instr_op_i(instr_op_i), .ring_i(ring_i), .px_rset_we_i(px_rset_we_i),
    .px_disp_we_i(px_disp_we_i), .mode_word_o(mode_word_o),
    .status_word_o(status_word_o), .refused_o(refused_o), .fault_o(fault_o),
    .interrupt_en_o(interrupt_en_o), .addr_mode_o(addr_mode_o),
    .int_hold_o(int_hold_o));
`default_nettype wire
